// [core/pumq_top.v]
// Purpose: Performance event counter with unit-mask qualification, AXI4-Lite slave.
// Assumes: Occurrence inputs are synchronous to clk and describe the selected event.
// Notes: The counter itself is never reset; software loads it before enabling.
//
// Function
// RQ1: Unit mask in selector bits 15:8 restricts which occurrences count.
// RQ2: Bits 15:14: 11 counts all cores, 01 this core, others reserved.
// RQ3: Core specificity applies only to flagged events on dual-core variant.
// RQ4: Bit 13 clear counts this bus agent only, set counts all agents.
// RQ5: Core-only events ignore core and agent encodings, count originating core.
// RQ6: Bits 13:12: 11 all, 01 prefetch only, 00 exclude prefetch, 10 reserved.
// RQ7: Agent and prefetch qualification never apply together to one event.
// RQ8: Bits 11:8 select modified, exclusive, shared, invalid states; bits combine.
// RQ9: MESI event with no state bit set never increments.
// RQ10: Snoop response: bit 11 modified hit, bit 9 hit, bit 8 clean.
// RQ11: Snoop type: bit 9 invalidating snoop, bit 8 sharing snoop.
// RQ12: At most one of MESI, snoop response, snoop type per event.
// RQ13: Counter is not cleared or preset by reset; contents undefined.
// RQ14: Software loads a known counter value before enabling counting.
// RQ15: Only defined sub-fields apply; reserved codes never widen counting.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pumq_defs.vh"

module pumq_top #(
    parameter ADDR_W = 8,
    parameter CNT_W = 40,
    parameter DUAL_CORE = 1
) (
    input wire clk,
    input wire reset_n,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [7:0] event_code,
    output wire counting_enabled,
    input wire occ_valid,
    input wire occ_this_core,
    input wire occ_this_agent,
    input wire occ_hw_prefetch,
    input wire [3:0] occ_line_state,
    input wire [2:0] occ_snoop_resp,
    input wire [1:0] occ_snoop_type,
    output wire count_pulse
);
    localparam HI_W = CNT_W - 32;

    // Register map, one aligned 32-bit word per offset:
    //   0x00 selector: event code in 7:0, unit mask in 15:8, enable in bit 22;
    //        every other bit is stored and read back unchanged
    //   0x04 event class, telling which sub-fields the selected event defines:
    //        bit 0 core specificity, bit 1 agent specificity, bit 2 prefetch,
    //        bits 4:3 low sub-field kind (none, line state, snoop response,
    //        snoop type), bit 5 core-only event; upper bits read as zero
    //   0x08 counter bits 31:0
    //   0x0C counter upper bits, zero-extended on read
    //   0x10 status: bit 0 sticky match, bit 1 class conflict, bit 2 live
    //        qualify result; only bit 0 reacts to a write (one clears it)
    // Any other offset answers with a slave error and changes nothing.
    //
    // The class comes from software rather than from a table keyed by the event
    // code, so new events need no logic change. The price is that a wrong class
    // mis-qualifies silently; the conflict bit catches only the agent and prefetch clash.

    // Register index decode, shared by the read and write paths
    // Index 0 means unmapped and leads to a slave error on either path
    function [2:0] reg_sel;
        input [ADDR_W-1:0] a;
        begin
            case (a[7:0])
                `PUMQ_OFF_SELECTOR: reg_sel = 3'h1;
                `PUMQ_OFF_CLASS: reg_sel = 3'h2;
                `PUMQ_OFF_CNT_LO: reg_sel = 3'h3;
                `PUMQ_OFF_CNT_HI: reg_sel = 3'h4;
                `PUMQ_OFF_STATUS: reg_sel = 3'h5;
                default: reg_sel = 3'h0;
            endcase
        end
    endfunction

    // Byte-lane merge of a write into an old word
    // Lanes whose strobe is clear keep their old byte
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // Programmed state and the counter
    reg [31:0] sel_q;
    reg [5:0] class_q;
    reg [CNT_W-1:0] cnt_q;
    reg match_seen_q;

    // Write channel holding registers
    reg aw_got_q;
    reg w_got_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    // Response registers
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // Qualifier results, decode and merged write words
    wire count_ok;
    wire class_conflict;
    wire do_write;
    wire [2:0] wsel;
    wire [2:0] rsel;
    wire [31:0] sel_merged;
    wire [31:0] class_merged;
    wire [31:0] lo_merged;
    wire [31:0] hi_merged;
    wire [31:0] cnt_hi_word;
    wire bump;

    // Filter for the currently selected event
    // Purely combinational; its result gates the increment in the same cycle
    pumq_qualifier #(
        .DUAL_CORE(DUAL_CORE)
    ) u_qual (
        .umask(sel_q[`PUMQ_UM_MSB:`PUMQ_UM_LSB]),
        .ev_class(class_q),
        .occ_this_core(occ_this_core),
        .occ_this_agent(occ_this_agent),
        .occ_hw_prefetch(occ_hw_prefetch),
        .occ_line_state(occ_line_state),
        .occ_snoop_resp(occ_snoop_resp),
        .occ_snoop_type(occ_snoop_type),
        .count_ok(count_ok),
        .class_conflict(class_conflict)
    );

    // Handshake outputs; one write and one read in flight at a time
    // Readies are combinational so an idle slave takes a request in its first cycle
    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign event_code = sel_q[`PUMQ_EVT_MSB:`PUMQ_EVT_LSB];
    assign counting_enabled = sel_q[`PUMQ_SEL_EN_BIT];

    // The pulse shows sources the decision in the cycle of the occurrence
    // RQ15: count only qualified occurrences
    assign bump = counting_enabled & occ_valid & count_ok;
    assign count_pulse = bump;

    // Write timing:
    //   edge 0: address and data taken, together or apart; each ready drops
    //   edge 1: the held pair is committed to the addressed register
    //   after edge 1: the response stands until bready is seen high
    // Holding both halves costs a cycle but keeps the decode off the bus inputs.
    // Write commits one cycle after both halves are held
    assign do_write = aw_got_q & w_got_q & ~bvalid_q;

    // Decode the held write address and the live read address
    assign wsel = reg_sel(awaddr_q);
    assign rsel = reg_sel(s_axi_araddr);

    // Upper counter word and the byte-merged candidates for each writable word
    assign cnt_hi_word = {{(32-HI_W){1'b0}}, cnt_q[CNT_W-1:32]};
    assign sel_merged = merge(sel_q, wdata_q, wstrb_q);
    assign class_merged = merge({26'h0, class_q}, wdata_q, wstrb_q);
    assign lo_merged = merge(cnt_q[31:0], wdata_q, wstrb_q);
    assign hi_merged = merge(cnt_hi_word, wdata_q, wstrb_q);

    // Write address and data channels, taken in either order
    // A standing response blocks both halves, so no write overtakes it
    always @(posedge clk) begin
        if (!reset_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `PUMQ_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                // Free both holders and raise the response
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wsel == 3'h0) ? `PUMQ_RESP_SLVERR : `PUMQ_RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Control registers; an unmapped or status offset leaves them alone
    always @(posedge clk) begin
        if (!reset_n) begin
            sel_q <= `PUMQ_SEL_RESET;
            class_q <= `PUMQ_CLS_RESET;
        end else if (do_write) begin
            if (wsel == 3'h1) begin
                sel_q <= sel_merged;
            end
            if (wsel == 3'h2) begin
                class_q <= class_merged[5:0];
            end
        end
    end

    // Sticky qualified-occurrence flag; a new occurrence beats the clear
    // Set wins so that no occurrence in the clearing cycle goes unreported
    always @(posedge clk) begin
        if (!reset_n) begin
            match_seen_q <= 1'b0;
        end else if (bump) begin
            match_seen_q <= 1'b1;
        end else if (do_write && wsel == 3'h5 && wstrb_q[0] && wdata_q[0]) begin
            match_seen_q <= 1'b0;
        end
    end

    // The counter spans two words with no snapshot: reading the low word and then
    // the high word can tear across a carry while counting is enabled, so software
    // that needs a coherent value stops counting first.
    // RQ13: counter left out of reset
    // RQ14: software load wins over a bump
    always @(posedge clk) begin
        if (do_write && wsel == 3'h3) begin
            cnt_q[31:0] <= lo_merged;
        end else if (do_write && wsel == 3'h4) begin
            cnt_q[CNT_W-1:32] <= hi_merged[HI_W-1:0];
        end else if (bump) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read timing: address taken at edge 0; data and response stand from the next
    // cycle until rready. The live status bit shows the decision of the edge-0 cycle,
    // and a status read does not clear the sticky bit.
    // Read channel; data held in a register until rready
    always @(posedge clk) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `PUMQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= `PUMQ_RESP_OKAY;
            case (rsel)
                3'h1: rdata_q <= sel_q;
                3'h2: rdata_q <= {26'h0, class_q};
                3'h3: rdata_q <= cnt_q[31:0];
                3'h4: rdata_q <= cnt_hi_word;
                3'h5: rdata_q <= {29'h0, count_ok, class_conflict, match_seen_q};
                // Unmapped: zero data with a slave error
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= `PUMQ_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // pumq_top

`default_nettype wire

// [core/pumq_defs.vh]
// Purpose: Shared constants for the event unit-mask qualifier.
// Assumes: Included by bare name from the core files.
// Notes: Byte offsets of the register bus and field positions of the selector.
`ifndef PUMQ_DEFS_VH
`define PUMQ_DEFS_VH

// Register byte offsets
`define PUMQ_OFF_SELECTOR 8'h00
`define PUMQ_OFF_CLASS 8'h04
`define PUMQ_OFF_CNT_LO 8'h08
`define PUMQ_OFF_CNT_HI 8'h0C
`define PUMQ_OFF_STATUS 8'h10

// Event selector fields
`define PUMQ_EVT_LSB 0
`define PUMQ_EVT_MSB 7
`define PUMQ_UM_LSB 8
`define PUMQ_UM_MSB 15
`define PUMQ_SEL_EN_BIT 22
`define PUMQ_SEL_RESET 32'h00000000

// Unit-mask sub-field positions, relative to unit-mask bit 0 (selector bit 8)
`define PUMQ_UM_CORE_HI 7
`define PUMQ_UM_CORE_LO 6
`define PUMQ_UM_AGENT 5
`define PUMQ_UM_PF_HI 5
`define PUMQ_UM_PF_LO 4

// Two-bit codes
`define PUMQ_CODE_ALL 2'h3
`define PUMQ_CODE_THIS 2'h1
`define PUMQ_CODE_PF_ONLY 2'h1
`define PUMQ_CODE_PF_EXCL 2'h0

// Event class register fields
`define PUMQ_CLS_CORE_BIT 0
`define PUMQ_CLS_AGENT_BIT 1
`define PUMQ_CLS_PF_BIT 2
`define PUMQ_CLS_ST_LSB 3
`define PUMQ_CLS_ST_MSB 4
`define PUMQ_CLS_CORE_ONLY_BIT 5
`define PUMQ_CLS_RESET 6'h00

// Overlapping low sub-field kinds
`define PUMQ_ST_NONE 2'h0
`define PUMQ_ST_MESI 2'h1
`define PUMQ_ST_SNP_RESP 2'h2
`define PUMQ_ST_SNP_TYPE 2'h3

// Bus responses
`define PUMQ_RESP_OKAY 2'h0
`define PUMQ_RESP_SLVERR 2'h2

`endif

// [core/pumq_qualifier.v]
// Purpose: Combinational filter deciding whether one occurrence is counted.
// Assumes: Occurrence attributes are valid together with the occurrence.
// Notes: Sub-fields the event class does not define are left out of the decision.
`timescale 1ns/1ns
`default_nettype none
`include "pumq_defs.vh"

module pumq_qualifier #(
    parameter DUAL_CORE = 1
) (
    input wire [7:0] umask,
    input wire [5:0] ev_class,
    input wire occ_this_core,
    input wire occ_this_agent,
    input wire occ_hw_prefetch,
    input wire [3:0] occ_line_state,
    input wire [2:0] occ_snoop_resp,
    input wire [1:0] occ_snoop_type,
    output wire count_ok,
    output wire class_conflict
);
    wire cls_core = ev_class[`PUMQ_CLS_CORE_BIT];
    wire cls_agent = ev_class[`PUMQ_CLS_AGENT_BIT];
    wire cls_pf = ev_class[`PUMQ_CLS_PF_BIT];
    wire cls_core_only = ev_class[`PUMQ_CLS_CORE_ONLY_BIT];
    wire [1:0] cls_st = ev_class[`PUMQ_CLS_ST_MSB:`PUMQ_CLS_ST_LSB];
    wire [1:0] core_code = umask[`PUMQ_UM_CORE_HI:`PUMQ_UM_CORE_LO];
    wire [1:0] pf_code = umask[`PUMQ_UM_PF_HI:`PUMQ_UM_PF_LO];
    reg core_ok;
    reg agent_ok;
    reg pf_ok;
    reg st_ok;

    // Agent and prefetch share bit 13; a class claiming both is flagged
    assign class_conflict = cls_agent & cls_pf;

    // Core specificity
    always @* begin
        core_ok = 1'b1;
        // RQ5: core-only ignores encodings
        if (cls_core_only) begin
            core_ok = occ_this_core;
        // RQ3: subset, dual-core only
        end else if (cls_core && (DUAL_CORE != 0)) begin
            // RQ2: all or this core
            case (core_code)
                `PUMQ_CODE_ALL: core_ok = 1'b1;
                `PUMQ_CODE_THIS: core_ok = occ_this_core;
                // RQ15: reserved counts nothing
                default: core_ok = 1'b0;
            endcase
        end
    end

    // Agent specificity, meaningless for core-only conditions
    always @* begin
        agent_ok = 1'b1;
        // RQ4: this agent or all
        if (cls_agent && !cls_core_only) begin
            agent_ok = umask[`PUMQ_UM_AGENT] | occ_this_agent;
        end
    end

    // Prefetch handling; agent wins bit 13 when both are claimed
    always @* begin
        pf_ok = 1'b1;
        // RQ7: never both applied
        if (cls_pf && !cls_agent) begin
            // RQ6: prefetch qualification
            case (pf_code)
                `PUMQ_CODE_ALL: pf_ok = 1'b1;
                `PUMQ_CODE_PF_ONLY: pf_ok = occ_hw_prefetch;
                `PUMQ_CODE_PF_EXCL: pf_ok = ~occ_hw_prefetch;
                // RQ15: reserved counts nothing
                default: pf_ok = 1'b0;
            endcase
        end
    end

    // Low sub-field; a two-bit kind lets only one overlay apply
    always @* begin
        st_ok = 1'b1;
        // RQ12: one overlapping sub-field
        case (cls_st)
            `PUMQ_ST_NONE: st_ok = 1'b1;
            // RQ8: MESI bits combine
            // RQ9: no state bit, no count
            `PUMQ_ST_MESI: st_ok = |(umask[3:0] & occ_line_state);
            // RQ10: snoop response, bit 10 ignored
            `PUMQ_ST_SNP_RESP: st_ok = (umask[3] & occ_snoop_resp[2]) |
                                       (umask[1] & occ_snoop_resp[1]) |
                                       (umask[0] & occ_snoop_resp[0]);
            // RQ11: snoop type
            `PUMQ_ST_SNP_TYPE: st_ok = (umask[1] & occ_snoop_type[1]) |
                                       (umask[0] & occ_snoop_type[0]);
            default: st_ok = 1'b0;
        endcase
    end

    // RQ1: unit mask restricts counting
    assign count_ok = core_ok & agent_ok & pf_ok & st_ok;
endmodule // pumq_qualifier

`default_nettype wire

// [dv/pumq_src_model.sv]
// Purpose: Event source model, one occurrence per call.
// Assumes: Caller orders the calls.
// Notes: Idle attributes invert so stale values never look real.
`timescale 1ns/1ns
`default_nettype none
module pumq_src_model (
    input wire logic clk,
    output logic occ_valid,
    output logic [11:0] occ_attr
);
    // Quiet at start
    initial begin
        occ_valid = 0;
        occ_attr = 12'h000;
    end
    // Offer one occurrence, return mid-cycle so the caller can sample
    task automatic emit(input logic [11:0] a);
        @(posedge clk);
        occ_valid <= 1;
        occ_attr <= a;
        @(negedge clk);
    endtask
    // Withdraw the occurrence
    task automatic idle();
        @(posedge clk);
        occ_valid <= 0;
        occ_attr <= ~occ_attr;
    endtask
endmodule // pumq_src_model
`default_nettype wire

// [dv/pumq_chk.sv]
// Purpose: Port relations of the qualifier top.
// Assumes: Bound into pumq_top.
// Notes: Write answer comes two cycles after both halves are taken.
`timescale 1ns/1ns
`default_nettype none
module pumq_chk #(parameter ADDR_W = 8) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic counting_enabled,
    input wire logic occ_valid,
    input wire logic count_pulse
);
    // All checks idle while reset is low
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_pulse_gated: assert property (count_pulse |-> occ_valid && counting_enabled)
        else $error("pulse without enabled occurrence");
    chk_enable_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr == 0 && s_axi_wstrb[2]
        |-> ##2 counting_enabled == $past(s_axi_wdata[22], 2)) else $error("enable not stored");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write answer");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer stuck");
    chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
endmodule // pumq_chk
bind pumq_top pumq_chk #(.ADDR_W(ADDR_W)) u_chk (.clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .counting_enabled, .occ_valid, .count_pulse);
`default_nettype wire

// [dv/pumq_top_bench.sv]
// Purpose: Self-checking bench for the unit-mask qualifier.
// Assumes: Counter is loaded before counting is enabled.
// Notes: Each case sets class and selector, then offers one occurrence.
`timescale 1ns/1ns
`default_nettype none
module perf_event_umask_qualifier_bench;
    logic clk = 0;
    logic reset_n = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [2:0] prot = 3'h0;
    wire logic awready, wready, bvalid, arready, rvalid, occ_valid, count_pulse, cnt_en;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] event_code;
    wire logic [11:0] at;
    int fails = 0;
    int tests_run = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    // Attributes: core, agent, prefetch, state[3:0], response[2:0], type[1:0]
    pumq_src_model src (.clk(clk), .occ_valid(occ_valid), .occ_attr(at));
    pumq_top dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .event_code(event_code), .counting_enabled(cnt_en), .occ_valid(occ_valid),
        .occ_this_core(at[11]), .occ_this_agent(at[10]), .occ_hw_prefetch(at[9]),
        .occ_line_state(at[8:5]), .occ_snoop_resp(at[4:2]), .occ_snoop_type(at[1:0]),
        .count_pulse(count_pulse));
    task automatic chk(input logic ok);
        tests_run++;
        if (ok !== 1'h1) begin
            fails++;
            $display("CHECK FAILED %0t value mismatch", $time);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Write: each half released when taken, no latency assumed
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk(bresp === r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk((rdata & m) === (e & m) && rresp === r);
    endtask
    // One qualified case: class, selector with enable, occurrence, verdict
    task automatic q(input logic [5:0] c, input logic [7:0] u, input logic [11:0] a, input logic e);
        wr(8'h04, {26'h0, c}, 2'h0);
        wr(8'h00, {9'h0, 1'h1, 6'h0, u, 8'h3C}, 2'h0);
        src.emit(a);
        chk(count_pulse === e);
        src.idle();
    endtask
    task automatic t_reset();
        rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
        rd(8'h04, 32'h0, 32'hFFFFFFFF, 2'h0);
        chk(event_code === 8'h00 && cnt_en === 1'h0);
        wr(8'h14, 32'h1, 2'h2);
        rd(8'h14, 32'h0, 32'hFFFFFFFF, 2'h2);
        // Byte strobes: only the unit-mask lane lands; protection bits are ignored
        wstrb <= 4'h2;
        prot <= 3'h7;
        wr(8'h00, 32'hFFFFFFFF, 2'h0);
        wstrb <= 4'hF;
        rd(8'h00, 32'h0000FF00, 32'hFFFFFFFF, 2'h0);
        prot <= 3'h0;
        chk(cnt_en === 1'h0);
    endtask
    // Carry from low word, two back-to-back occurrences
    task automatic t_count();
        wr(8'h08, 32'hFFFFFFFF, 2'h0);
        wr(8'h0C, 32'h0, 2'h0);
        wr(8'h00, 32'h0040003C, 2'h0);
        chk(event_code === 8'h3C && cnt_en === 1'h1);
        src.emit(12'h000);
        chk(count_pulse === 1'h1);
        src.emit(12'h000);
        chk(count_pulse === 1'h1);
        src.idle();
        // Sticky match seen and live qualify result, then write one to clear
        rd(8'h10, 32'h5, 32'h5, 2'h0);
        wr(8'h10, 32'h1, 2'h0);
        rd(8'h10, 32'h4, 32'h5, 2'h0);
        rd(8'h08, 32'h1, 32'hFFFFFFFF, 2'h0);
        rd(8'h0C, 32'h1, 32'hFF, 2'h0);
        wr(8'h00, 32'h3C, 2'h0);
        src.emit(12'h000);
        chk(count_pulse === 1'h0);
        src.idle();
    endtask
    task automatic t_core();
        int i, c;
        for (i = 0; i < 4; i++) for (c = 0; c < 2; c++)
            q(6'h01, {i[1:0], 6'h0}, {c[0], 11'h0}, i == 3 || (i == 1 && c == 1));
        q(6'h23, 8'h00, 12'h800, 1'h1);
        q(6'h23, 8'h00, 12'h400, 1'h0);
    endtask
    task automatic t_agent();
        int b, g;
        for (b = 0; b < 2; b++) for (g = 0; g < 2; g++)
            q(6'h02, {2'h0, b[0], 5'h0}, {1'h0, g[0], 10'h0}, b == 1 || g == 1);
        q(6'h06, 8'h20, 12'h000, 1'h1);
        rd(8'h10, 32'h2, 32'h2, 2'h0);
    endtask
    task automatic t_pf();
        int i, p;
        for (i = 0; i < 4; i++) for (p = 0; p < 2; p++)
            q(6'h04, {2'h0, i[1:0], 4'h0}, {2'h0, p[0], 9'h0},
                i == 3 || (i == 1 && p == 1) || (i == 0 && p == 0));
    endtask
    task automatic t_low();
        int u, s;
        for (u = 0; u < 16; u++) for (s = 0; s < 4; s++)
            q(6'h08, {4'h0, u[3:0]}, {3'h0, 4'h1 << s, 5'h0}, u[s]);
        q(6'h08, 8'h0F, 12'h01F, 1'h0);
        for (u = 0; u < 16; u++) for (s = 0; s < 3; s++)
            q(6'h10, {4'h0, u[3:0]}, {7'h0, 3'h1 << s, 2'h0}, (s == 2) ? u[3] : u[s]);
        for (u = 0; u < 4; u++) for (s = 0; s < 2; s++)
            q(6'h18, {6'h0, u[1:0]}, {10'h0, 2'h1 << s}, u[s]);
    endtask
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        t_reset();
        t_count();
        t_core();
        t_agent();
        t_pf();
        t_low();
        end_sim();
    end
    // Cut a hang well past the expected run length
    initial begin
        #400000;
        fails++;
        end_sim();
    end
endmodule // perf_event_umask_qualifier_bench
`default_nettype wire
